// file: inc/el1_access_if.sv
`default_nettype none

// Access context handed from the register file to the route decoder
interface el1_access_if;
  import el1_label_pkg::*;
  logic hit; // Encoding matches either form
  logic isAlt; // Alternate encoding used
  logic [1:0] el; // Current exception level
  logic el2En; // Second level present and enabled
  logic el2Is64; // Second level in 64-bit state
  logic el3Is64; // Third level in 64-bit state
  logic hostAtEl2; // Host runs at the second level
  logic trap_lower_levels; // Third level traps lower accesses
  logic trapEl1; // Second level traps first-level access
  logic [2:0] nvBits; // Nested virtualization controls
  route_t route; // Decision
  modport regfile (output hit, isAlt, el, el2En, el2Is64, el3Is64,
    hostAtEl2, trap_lower_levels, trapEl1, nvBits, input route);
  modport decoder (input hit, isAlt, el, el2En, el2Is64, el3Is64,
    hostAtEl2, trap_lower_levels, trapEl1, nvBits, output route);
endinterface

`default_nettype wire

// file: inc/el1_label_cfg.svh
`ifndef EL1_LABEL_CFG_SVH
`define EL1_LABEL_CFG_SVH

// Encoding fields of both encodings of this register; op1 differs between them
`define LBL_OP0 2'h3
`define LBL_OP1_PRI 3'h0
`define LBL_OP1_ALT 3'h5
`define LBL_CRN 4'hA
`define LBL_CRM 4'h5
`define LBL_OP2 3'h0

// Trap syndrome class for system register access traps
`define LBL_SYNDROME 6'h18

// Shadow location used under nested virtualization
`define LBL_SHADOW_OFFSET 12'h900

// Nested-virtualization codes of {nv2, nv1, nv}
`define LBL_NV_SHADOW_PRI 3'h7
`define LBL_NV_SHADOW_ALT 3'h5

// Field positions
`define LBL_EN_BIT 63
`define LBL_FNS_BIT 60
`define LBL_DATA_MONITOR_GROUP_HI 47
`define LBL_DATA_MONITOR_GROUP_LO 40
`define LBL_INSTR_MONITOR_GROUP_HI 39
`define LBL_INSTR_MONITOR_GROUP_LO 32
`define LBL_PID_D_HI 31
`define LBL_PID_D_LO 16
`define LBL_PID_I_HI 15
`define LBL_PID_I_LO 0

// Reset value of the local enable copy
`define LBL_EN_RESET 1'h0

`endif

// file: inc/el1_label_pkg.sv
`default_nettype none

package el1_label_pkg;
  // Where one system register access ends up
  typedef enum logic [2:0] {
    ROUTE_NONE,
    ROUTE_UNDEF,
    ROUTE_TRAP_EL3,
    ROUTE_TRAP_EL2,
    ROUTE_SHADOW,
    ROUTE_REG,
    ROUTE_EL2_REG
  } route_t;
endpackage

`default_nettype wire

// file: rtl/el1_access_decode.sv
`include "el1_label_cfg.svh"
`default_nettype none

module el1_access_decode
  import el1_label_pkg::*;
#(
  parameter bit HAS_EL2 = 1'b1,
  parameter bit HAS_EL3 = 1'b1,
  parameter bit HAS_PART_EXT = 1'b1
) (
  el1_access_if.decoder acc
);

  // Third-level trap condition, shared by several levels
  wire trapToEl3 = HAS_EL3 && acc.trap_lower_levels;
  // First-level trap to level three also needs 64-bit state there
  wire trapEl1ToEl3 = trapToEl3 && acc.el3Is64;
  // Second-level trap of first-level access
  wire trapEl1ToEl2 = acc.el2En && acc.el2Is64 && acc.trapEl1;
  // Shadow conditions per encoding
  wire shadowPri = acc.el2En && acc.el2Is64 && (acc.nvBits == `LBL_NV_SHADOW_PRI);
  wire shadowAlt = acc.el2En && (acc.nvBits == `LBL_NV_SHADOW_ALT);

  // Primary encoding route
  wire route_t priRoute =
    (acc.el == 2'h0) ? ROUTE_UNDEF :
    (acc.el == 2'h1) ? (trapEl1ToEl3 ? ROUTE_TRAP_EL3 :
                        trapEl1ToEl2 ? ROUTE_TRAP_EL2 :
                        shadowPri ? ROUTE_SHADOW : ROUTE_REG) :
    (acc.el == 2'h2) ? (trapToEl3 ? ROUTE_TRAP_EL3 :
                        acc.hostAtEl2 ? ROUTE_EL2_REG : ROUTE_REG) :
    ROUTE_REG;

  // Alternate encoding route
  wire route_t altRoute =
    (acc.el == 2'h0) ? ROUTE_UNDEF :
    (acc.el == 2'h1) ? (shadowAlt ? ROUTE_SHADOW :
                        (acc.el2En && acc.nvBits[0]) ?
                          (trapEl1ToEl3 ? ROUTE_TRAP_EL3 : ROUTE_TRAP_EL2) :
                        ROUTE_UNDEF) :
    (acc.el == 2'h2) ? (!acc.hostAtEl2 ? ROUTE_UNDEF :
                        trapToEl3 ? ROUTE_TRAP_EL3 : ROUTE_REG) :
    ((acc.el2En && acc.el2Is64 && acc.hostAtEl2) ? ROUTE_REG : ROUTE_UNDEF);

  // Final decision; missing extension makes every hit undefined
  assign acc.route = !acc.hit ? ROUTE_NONE :
                     !HAS_PART_EXT ? ROUTE_UNDEF :
                     acc.isAlt ? altRoute : priRoute;

endmodule // el1_access_decode

`default_nettype wire

// file: rtl/el1_partition_label_reg.sv
// Contract
// - Register forms labels for first-level requests
// - Labels lowest-level apps under guest conditions
// - Second level with host redirects primary encoding to the second-level register
// - Alternate encoding reaches register with host
// - Virtual IDs translated when mapping enabled
// - Translation also applies to borrowed app labels
// - Enable bit shared with higher level copy
// - Enable zero gives default labels everywhere
// - Enable writable only without higher levels
// - Enable clears to zero on reset
// - Bit 60 shows forced nonsecure when secure
// - Monitor groups at 47:40 and 39:32
// - Data ID 31:16, instruction ID 15:0
// - Label fields unspecified after reset
// - Labels always from live register value
// - No extension means access undefined
// - Primary encoding 3,0,10,5,0 for both
// - Lowest level access is undefined
// - First-level writes trap third then second
// - Nested condition writes go to shadow
// - Second-level traps to third; third always reaches via primary encoding
`include "el1_label_cfg.svh"
`default_nettype none

module el1_partition_label_reg
  import el1_label_pkg::*;
#(
  parameter bit HAS_EL2 = 1'b1, // Second level implemented
  parameter bit HAS_EL3 = 1'b1, // Third level implemented
  parameter bit HAS_PART_EXT = 1'b1, // Partitioning extension present
  parameter bit HAS_VIRT = 1'b1, // Virtualization option present
  parameter bit HAS_NEW_REV = 1'b1, // Newer extension revision
  parameter logic [15:0] DEFAULT_PARTID = 16'h0000, // Default partition ID
  parameter logic [7:0] DEFAULT_PMG = 8'h00 // Default monitoring group
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic accValid,
  input wire logic accWrite,
  input wire logic [1:0] accOp0,
  input wire logic [2:0] accOp1,
  input wire logic [3:0] accCrn,
  input wire logic [3:0] accCrm,
  input wire logic [2:0] accOp2,
  input wire logic [63:0] accWdata,
  input wire logic [1:0] curEl,
  input wire logic secureState,
  input wire logic el2Enabled,
  input wire logic el2Uses64Bit,
  input wire logic el3Uses64Bit,
  input wire logic hostAtEl2,
  input wire logic trapGeneralExceptions,
  input wire logic [2:0] nestedVirtBits,
  input wire logic trapLowerLevels,
  input wire logic trapEl1LabelAccess,
  input wire logic guestAppUsesKernelLabel,
  input wire logic el1VirtIdMapEn,
  input wire logic forceNonsecure,
  input wire logic el3LabelGenEnable,
  input wire logic el2LabelGenEnable,
  input wire logic [63:0] el2LabelValue,
  input wire logic [63:0] shadowReadData,
  output logic accDone,
  output logic [63:0] accRdata,
  output logic accUndef,
  output logic accTrap,
  output logic [1:0] accTrapEl,
  output logic [5:0] accSyndrome,
  output logic accToEl2Reg,
  output logic [63:0] accEl2Wdata,
  output logic accShadow,
  output logic [11:0] accShadowOffset,
  output logic [63:0] accShadowWdata,
  output logic labelFromThis,
  output logic labelEl0Borrow,
  output logic labelVirtual,
  output logic labelEnabled,
  output logic [15:0] labelDataPartId,
  output logic [15:0] labelInstrPartId,
  output logic [7:0] labelDataMonGroup,
  output logic [7:0] labelInstrMonGroup
);

  // Stored label fields; no reset on purpose, software programs them
  logic [47:0] fields_reg;
  // Local enable, used only when no higher level owns the bit
  logic enable_reg;
  // Response registers
  logic done_reg;
  logic [63:0] rdata_reg;
  logic undef_reg;
  logic trap_reg;
  logic [1:0] trapEl_reg;
  logic [5:0] syndrome_reg;
  logic toEl2_reg;
  logic [63:0] el2Wdata_reg;
  logic shadow_reg;
  logic [63:0] shadowWdata_reg;
  // Label output registers
  logic fromThis_reg;
  logic borrow_reg;
  logic virtual_reg;
  logic enabled_reg;
  logic [15:0] pidD_reg;
  logic [15:0] pidI_reg;
  logic [7:0] pmgD_reg;
  logic [7:0] pmgI_reg;

  // Route decoder shares the access context
  el1_access_if acc ();

  // Encoding match against both forms
  wire encCommon = (accOp0 == `LBL_OP0) && (accCrn == `LBL_CRN) &&
                   (accCrm == `LBL_CRM) && (accOp2 == `LBL_OP2);
  // Primary form
  wire encPri = encCommon && (accOp1 == `LBL_OP1_PRI);
  // Alternate form
  wire encAlt = encCommon && (accOp1 == `LBL_OP1_ALT);

  // Context into the decoder
  assign acc.hit = accValid && (encPri || encAlt);
  assign acc.isAlt = encAlt;
  assign acc.el = curEl;
  assign acc.el2En = HAS_EL2 && el2Enabled;
  assign acc.el2Is64 = el2Uses64Bit;
  assign acc.el3Is64 = el3Uses64Bit;
  assign acc.hostAtEl2 = hostAtEl2;
  assign acc.trap_lower_levels = trapLowerLevels;
  assign acc.trapEl1 = trapEl1LabelAccess;
  assign acc.nvBits = nestedVirtBits;

  // Trap and redirect decision
  el1_access_decode #(
    .HAS_EL2(HAS_EL2),
    .HAS_EL3(HAS_EL3),
    .HAS_PART_EXT(HAS_PART_EXT)
  ) u_decode (
    .acc(acc)
  );

  // Decoded route of this cycle
  wire route_t route = acc.route;
  // Plain register reached
  wire hitReg = (route == ROUTE_REG);
  // Register write taken
  wire regWrite = hitReg && accWrite;

  // Enable seen by everyone: shared storage with the highest level
  wire enLive = HAS_EL3 ? el3LabelGenEnable :
                HAS_EL2 ? el2LabelGenEnable : enable_reg;
  // Enable writable only when this register owns it
  wire enWritable = !HAS_EL3 && !HAS_EL2;

  // Forced nonsecure view: reads zero outside secure state
  wire fnsView = HAS_NEW_REV && secureState && forceNonsecure;

  // Live read image; reserved bits read zero
  wire [63:0] readImage = {enLive, 2'h0, fnsView, 12'h000, fields_reg};

  // Read data by route
  wire [63:0] readData = (route == ROUTE_EL2_REG) ? el2LabelValue :
                         (route == ROUTE_SHADOW) ? shadowReadData :
                         hitReg ? readImage : 64'h0000_0000_0000_0000;

  // Trap routes
  wire isTrap = (route == ROUTE_TRAP_EL3) || (route == ROUTE_TRAP_EL2);
  // Level that takes the trap
  wire [1:0] trapTarget = (route == ROUTE_TRAP_EL3) ? 2'h3 : 2'h2;

  // Guest applications borrow this register
  wire el0Borrow = HAS_EL2 && el2Enabled && HAS_VIRT &&
                   guestAppUsesKernelLabel && !trapGeneralExceptions;
  // This register labels the current request
  wire useThis = HAS_PART_EXT && ((curEl == 2'h1) ||
                 ((curEl == 2'h0) && el0Borrow));
  // IDs are virtual, including borrowed app labels
  wire idsVirtual = useThis && enLive && HAS_EL2 && el2Enabled &&
                    HAS_VIRT && el1VirtIdMapEn;

  // Label fields straight from stored value, never a cached copy
  wire [15:0] pidD = fields_reg[`LBL_PID_D_HI:`LBL_PID_D_LO];
  wire [15:0] pidI = fields_reg[`LBL_PID_I_HI:`LBL_PID_I_LO];
  wire [7:0] pmgD = fields_reg[`LBL_DATA_MONITOR_GROUP_HI:`LBL_DATA_MONITOR_GROUP_LO];
  wire [7:0] pmgI = fields_reg[`LBL_INSTR_MONITOR_GROUP_HI:`LBL_INSTR_MONITOR_GROUP_LO];

  // Field storage; writes through other routes never land here
  always_ff @(posedge clk) begin
    if (regWrite) begin
      fields_reg <= accWdata[47:0];
    end
  end

  // Local enable copy; bit 60 writes simply dropped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enable_reg <= `LBL_EN_RESET;
    end else if (regWrite && enWritable) begin
      enable_reg <= accWdata[`LBL_EN_BIT];
    end
  end

  // Access response, one cycle after the request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_reg <= 1'b0;
      rdata_reg <= 64'h0000_0000_0000_0000;
      undef_reg <= 1'b0;
      trap_reg <= 1'b0;
      trapEl_reg <= 2'h0;
      syndrome_reg <= 6'h00;
      toEl2_reg <= 1'b0;
      el2Wdata_reg <= 64'h0000_0000_0000_0000;
      shadow_reg <= 1'b0;
      shadowWdata_reg <= 64'h0000_0000_0000_0000;
    end else begin
      done_reg <= (route != ROUTE_NONE);
      // Read data only for reads
      rdata_reg <= accWrite ? 64'h0000_0000_0000_0000 : readData;
      undef_reg <= (route == ROUTE_UNDEF);
      trap_reg <= isTrap;
      trapEl_reg <= isTrap ? trapTarget : 2'h0;
      syndrome_reg <= isTrap ? `LBL_SYNDROME : 6'h00;
      toEl2_reg <= (route == ROUTE_EL2_REG);
      el2Wdata_reg <= accWdata;
      shadow_reg <= (route == ROUTE_SHADOW);
      shadowWdata_reg <= accWdata;
    end
  end

  // Labels refreshed every cycle from the live value
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fromThis_reg <= 1'b0;
      borrow_reg <= 1'b0;
      virtual_reg <= 1'b0;
      enabled_reg <= 1'b0;
      pidD_reg <= DEFAULT_PARTID;
      pidI_reg <= DEFAULT_PARTID;
      pmgD_reg <= DEFAULT_PMG;
      pmgI_reg <= DEFAULT_PMG;
    end else begin
      fromThis_reg <= useThis;
      borrow_reg <= useThis && (curEl == 2'h0);
      virtual_reg <= idsVirtual;
      enabled_reg <= enLive;
      // Disabled: defaults for every request
      pidD_reg <= (enLive && useThis) ? pidD : DEFAULT_PARTID;
      pidI_reg <= (enLive && useThis) ? pidI : DEFAULT_PARTID;
      pmgD_reg <= (enLive && useThis) ? pmgD : DEFAULT_PMG;
      pmgI_reg <= (enLive && useThis) ? pmgI : DEFAULT_PMG;
    end
  end

  // Outputs straight from flops, except the constant shadow offset
  assign accDone = done_reg;
  assign accRdata = rdata_reg;
  assign accUndef = undef_reg;
  assign accTrap = trap_reg;
  assign accTrapEl = trapEl_reg;
  assign accSyndrome = syndrome_reg;
  assign accToEl2Reg = toEl2_reg;
  assign accEl2Wdata = el2Wdata_reg;
  assign accShadow = shadow_reg;
  // Fixed offset, constant from reset on
  assign accShadowOffset = `LBL_SHADOW_OFFSET;
  assign accShadowWdata = shadowWdata_reg;
  assign labelFromThis = fromThis_reg;
  assign labelEl0Borrow = borrow_reg;
  assign labelVirtual = virtual_reg;
  assign labelEnabled = enabled_reg;
  assign labelDataPartId = pidD_reg;
  assign labelInstrPartId = pidI_reg;
  assign labelDataMonGroup = pmgD_reg;
  assign labelInstrMonGroup = pmgI_reg;

endmodule // el1_partition_label_reg

`default_nettype wire

// file: sim/el1_far_side_model.sv
`default_nettype none

// Second-level register and shadow memory seen from the block
module el1_far_side_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic accValid,
  input wire logic accWrite,
  input wire logic accToEl2Reg,
  input wire logic accShadow,
  input wire logic [63:0] accEl2Wdata,
  input wire logic [63:0] accShadowWdata,
  output logic [63:0] el2LabelValue,
  output logic [63:0] shadowReadData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wrPend; // Access in flight is a write
  // Stores only on write answers; reads leave contents alone
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPend <= 1'b0;
      el2LabelValue <= 64'hC3A5_0F1E_7D24_9B60;
      shadowReadData <= 64'h3C5A_F0E1_82DB_649F;
    end else begin
      wrPend <= accValid && accWrite;
      if (wrPend && accToEl2Reg) el2LabelValue <= accEl2Wdata;
      if (wrPend && accShadow) shadowReadData <= accShadowWdata;
    end
  end
endmodule // el1_far_side_model

`default_nettype wire

// file: sim/el1_label_asserts.sv
`include "el1_label_cfg.svh"
`default_nettype none

module el1_label_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic accValid,
  input wire logic accWrite,
  input wire logic [1:0] accOp0,
  input wire logic [2:0] accOp1,
  input wire logic [3:0] accCrn,
  input wire logic [3:0] accCrm,
  input wire logic [2:0] accOp2,
  input wire logic [1:0] curEl,
  input wire logic secureState,
  input wire logic el2Enabled,
  input wire logic el2Uses64Bit,
  input wire logic el3Uses64Bit,
  input wire logic hostAtEl2,
  input wire logic [2:0] nestedVirtBits,
  input wire logic trapLowerLevels,
  input wire logic trapEl1LabelAccess,
  input wire logic forceNonsecure,
  input wire logic el3LabelGenEnable,
  input wire logic accDone,
  input wire logic [63:0] accRdata,
  input wire logic accUndef,
  input wire logic accTrap,
  input wire logic [1:0] accTrapEl,
  input wire logic [5:0] accSyndrome,
  input wire logic accToEl2Reg,
  input wire logic accShadow,
  input wire logic [11:0] accShadowOffset,
  input wire logic labelEnabled,
  input wire logic [15:0] labelDataPartId,
  input wire logic [15:0] labelInstrPartId
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Shared tail of both encodings
  wire logic tail = accOp0 == `LBL_OP0 && accCrn == `LBL_CRN && accCrm == `LBL_CRM
    && accOp2 == `LBL_OP2;
  wire logic take = accValid && tail && accOp1 == `LBL_OP1_PRI; // Primary request
  wire logic altTake = accValid && tail && accOp1 == `LBL_OP1_ALT; // Alternate request
  wire logic up3 = el3Uses64Bit && trapLowerLevels; // Third level traps lower
  wire logic el2On = el2Enabled && el2Uses64Bit; // Second level usable

  a_undef_low: assert property (take && curEl == 2'h0 |=> accDone && accUndef)
    else $error("lowest level access not undefined");
  a_trap_third: assert property (take && curEl == 2'h1 && up3 |=> accTrap
    && accTrapEl == 2'h3 && accSyndrome == `LBL_SYNDROME) else $error("no trap to third");
  a_trap_second: assert property (take && curEl == 2'h1 && !up3 && el2On
    && trapEl1LabelAccess |=> accTrap && accTrapEl == 2'h2) else $error("no trap to second");
  a_shadow_write: assert property (take && curEl == 2'h1 && !up3 && el2On
    && !trapEl1LabelAccess && nestedVirtBits == `LBL_NV_SHADOW_PRI
    |=> accShadow && accShadowOffset == `LBL_SHADOW_OFFSET) else $error("shadow access missing");
  a_host_redirect: assert property (take && curEl == 2'h2 && hostAtEl2 && !trapLowerLevels
    |=> accToEl2Reg && !accTrap) else $error("no redirect at second level");
  a_no_match: assert property (accValid && !take && !altTake |=> !accDone)
    else $error("foreign encoding answered");
  a_alt_third: assert property (altTake && curEl == 2'h3 && el2On && hostAtEl2
    |=> accDone && !accUndef && !accTrap) else $error("alternate encoding refused");
  a_third_read: assert property (take && !accWrite && curEl == 2'h3
    |=> accDone && !accTrap && accRdata[62:61] == 2'h0 && accRdata[59:48] == 12'h000
    && accRdata[60] == ($past(secureState) && $past(forceNonsecure)))
    else $error("read image wrong");
  a_enable_live: assert property (!$past(reset)
    |-> labelEnabled == $past(el3LabelGenEnable)) else $error("enable copy not followed");
  a_default_off: assert property (!labelEnabled |-> labelDataPartId == 16'h0000
    && labelInstrPartId == 16'h0000) else $error("labels not default");

  // Main paths reached
  c_shadow: cover property (take ##1 accShadow);
  c_redirect: cover property (take ##1 accToEl2Reg);
  c_trap: cover property (accTrap && accTrapEl == 2'h3);
endmodule // el1_label_checker

bind el1_partition_label_reg el1_label_checker chk (.clk, .reset, .accValid, .accWrite, .accOp0,
  .accOp1, .accCrn, .accCrm, .accOp2, .curEl, .secureState, .el2Enabled, .el2Uses64Bit,
  .el3Uses64Bit, .hostAtEl2, .nestedVirtBits, .trapLowerLevels, .trapEl1LabelAccess,
  .forceNonsecure, .el3LabelGenEnable, .accDone, .accRdata, .accUndef, .accTrap, .accTrapEl,
  .accSyndrome, .accToEl2Reg, .accShadow, .accShadowOffset, .labelEnabled, .labelDataPartId,
  .labelInstrPartId);

`default_nettype wire

// file: sim/tb_el1_partition_label_reg.sv
`include "el1_label_cfg.svh"
`default_nettype none

module tb_el1_partition_label_reg import el1_label_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, accValid, accWrite, secureState, el2Enabled, el2Uses64Bit, el3Uses64Bit;
  logic hostAtEl2, trapGeneralExceptions, trapLowerLevels, trapEl1LabelAccess, forceNonsecure;
  logic guestAppUsesKernelLabel, el1VirtIdMapEn, el3LabelGenEnable, el2LabelGenEnable;
  logic [1:0] accOp0, curEl, accTrapEl;
  logic [2:0] accOp1, accOp2, nestedVirtBits;
  logic [3:0] accCrn, accCrm;
  logic [5:0] accSyndrome;
  logic [11:0] accShadowOffset;
  logic [63:0] accWdata, el2LabelValue, shadowReadData, accRdata, accEl2Wdata, accShadowWdata;
  logic accDone, accUndef, accTrap, accToEl2Reg, accShadow, labelFromThis, labelEl0Borrow;
  logic labelVirtual, labelEnabled;
  logic [15:0] labelDataPartId, labelInstrPartId;
  logic [7:0] labelDataMonGroup, labelInstrMonGroup;
  logic [47:0] mdl; // Reference copy of stored fields
  int failures, comparisons;

  el1_partition_label_reg dut (.clk, .reset, .accValid, .accWrite, .accOp0, .accOp1, .accCrn,
    .accCrm, .accOp2, .accWdata, .curEl, .secureState, .el2Enabled, .el2Uses64Bit, .el3Uses64Bit,
    .hostAtEl2, .trapGeneralExceptions, .nestedVirtBits, .trapLowerLevels, .trapEl1LabelAccess,
    .guestAppUsesKernelLabel, .el1VirtIdMapEn, .forceNonsecure, .el3LabelGenEnable,
    .el2LabelGenEnable, .el2LabelValue, .shadowReadData, .accDone, .accRdata, .accUndef, .accTrap,
    .accTrapEl, .accSyndrome, .accToEl2Reg, .accEl2Wdata, .accShadow, .accShadowOffset,
    .accShadowWdata, .labelFromThis, .labelEl0Borrow, .labelVirtual, .labelEnabled,
    .labelDataPartId, .labelInstrPartId, .labelDataMonGroup, .labelInstrMonGroup);
  el1_far_side_model far (.clk, .reset, .accValid, .accWrite, .accToEl2Reg, .accShadow,
    .accEl2Wdata, .accShadowWdata, .el2LabelValue, .shadowReadData);

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cmpVal(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmpRoute(input route_t got, input route_t exp);
    cmpVal(64'(got), 64'(exp));
  endtask

  // Reference routing, written from the access tables
  function automatic route_t expRoute(input logic alt, input logic bad);
    logic t3;
    t3 = el3Uses64Bit && trapLowerLevels;
    if (bad) return ROUTE_NONE;
    if (curEl == 2'h0) return ROUTE_UNDEF;
    if (curEl == 2'h1 && !alt) begin
      if (t3) return ROUTE_TRAP_EL3;
      if (el2Enabled && el2Uses64Bit && trapEl1LabelAccess) return ROUTE_TRAP_EL2;
      return (el2Enabled && el2Uses64Bit && nestedVirtBits == 3'h7) ? ROUTE_SHADOW : ROUTE_REG;
    end
    if (curEl == 2'h1) begin
      if (el2Enabled && nestedVirtBits == 3'h5) return ROUTE_SHADOW;
      if (!(el2Enabled && nestedVirtBits[0])) return ROUTE_UNDEF;
      return t3 ? ROUTE_TRAP_EL3 : ROUTE_TRAP_EL2;
    end
    if (curEl == 2'h2 && alt && !hostAtEl2) return ROUTE_UNDEF;
    if (curEl == 2'h2 && trapLowerLevels) return ROUTE_TRAP_EL3;
    if (curEl == 2'h2) return (hostAtEl2 && !alt) ? ROUTE_EL2_REG : ROUTE_REG;
    if (!alt) return ROUTE_REG;
    return (el2Enabled && el2Uses64Bit && hostAtEl2) ? ROUTE_REG : ROUTE_UNDEF;
  endfunction

  // Route as shown by the answer pulses
  function automatic route_t obsRoute();
    if (accDone !== 1'b1) return ROUTE_NONE;
    if (accUndef === 1'b1) return ROUTE_UNDEF;
    if (accTrap === 1'b1) return (accTrapEl === 2'h3) ? ROUTE_TRAP_EL3 : ROUTE_TRAP_EL2;
    if (accShadow === 1'b1) return ROUTE_SHADOW;
    return (accToEl2Reg === 1'b1) ? ROUTE_EL2_REG : ROUTE_REG;
  endfunction

  // One access: label check, request, answer check; spaced, never back to back
  task automatic acc(input logic wr, input logic alt, input logic bad, input logic rnd);
    route_t er;
    logic own; // This register labels the current level
    logic [47:0] lab; // Label outputs in register field order
    @(posedge clk);
    #1;
    own = curEl == 2'h1 || (curEl == 2'h0 && el2Enabled && guestAppUsesKernelLabel
      && !trapGeneralExceptions);
    lab = {labelDataMonGroup, labelInstrMonGroup, labelDataPartId, labelInstrPartId};
    cmpVal(labelEnabled, el3LabelGenEnable);
    cmpVal(lab, (own && el3LabelGenEnable) ? mdl : 48'h0);
    cmpVal(labelFromThis, own);
    cmpVal(labelEl0Borrow, own && curEl == 2'h0);
    cmpVal(labelVirtual, own && el3LabelGenEnable && el2Enabled && el1VirtIdMapEn);
    @(posedge clk);
    accValid <= 1'b1;
    accWrite <= wr;
    accOp1 <= alt ? `LBL_OP1_ALT : `LBL_OP1_PRI;
    accCrm <= bad ? 4'h6 : `LBL_CRM;
    accWdata <= {$urandom, $urandom};
    if (rnd) begin
      {curEl, secureState, el2Enabled, el2Uses64Bit, el3Uses64Bit, hostAtEl2,
        trapGeneralExceptions, nestedVirtBits, trapLowerLevels, trapEl1LabelAccess,
        guestAppUsesKernelLabel, el1VirtIdMapEn, forceNonsecure, el3LabelGenEnable,
        el2LabelGenEnable} <= 18'($urandom);
    end
    @(posedge clk);
    accValid <= 1'b0;
    #1;
    er = expRoute(alt, bad);
    cmpRoute(obsRoute(), er);
    if (er == ROUTE_TRAP_EL3 || er == ROUTE_TRAP_EL2) cmpVal(accSyndrome, `LBL_SYNDROME);
    if (er == ROUTE_EL2_REG && !wr) cmpVal(accRdata, el2LabelValue);
    if (er == ROUTE_REG && !wr) cmpVal(accRdata, {el3LabelGenEnable, 2'h0,
      secureState && forceNonsecure, 12'h000, mdl});
    if (er == ROUTE_SHADOW && !wr) cmpVal(accRdata, shadowReadData);
    if (er == ROUTE_SHADOW && wr) cmpVal(accShadowWdata, accWdata);
    if (er == ROUTE_EL2_REG && wr) cmpVal(accEl2Wdata, accWdata);
    if (er == ROUTE_REG && wr) mdl = accWdata[47:0];
  endtask

  task automatic conclude();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    {accValid, accWrite, accOp1, accWdata, nestedVirtBits, secureState, forceNonsecure} = '0;
    {el2Enabled, el2Uses64Bit, el3Uses64Bit, hostAtEl2, trapGeneralExceptions} = '0;
    {trapLowerLevels, trapEl1LabelAccess, guestAppUsesKernelLabel, el1VirtIdMapEn} = '0;
    {el3LabelGenEnable, el2LabelGenEnable} = 2'h3;
    {accOp0, accCrn, accCrm, accOp2, curEl} = {`LBL_OP0, `LBL_CRN, `LBL_CRM, `LBL_OP2, 2'h3};
    mdl = 'x;
    reset = 1'b1;
    void'($urandom(18));
    repeat (16) @(posedge clk);
    cmpVal({labelEnabled, accDone}, 2'h0);
    reset <= 1'b0;
    acc(1'b1, 1'b0, 1'b0, 1'b0);
    acc(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test directed done");
    // Mixed encodings are spaced by idle cycles, as software must order them
    repeat (500) acc(1'($urandom), 1'($urandom), ($urandom % 8) == 0, 1'b1);
    $display("test random done");
    @(posedge clk);
    reset <= 1'b1;
    #1;
    cmpVal(labelEnabled, 1'b0);
    $display("test second reset done");
    conclude();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule // tb_el1_partition_label_reg

`default_nettype wire
